// >>> inc/cdfo_pkg.sv
package cdfo_pkg;
    localparam logic [4:0] CDFO_ADDR_FIXED = 5'h1a;
    localparam logic [7:0] CDFO_REG_MASK_OFS = 8'h00;
    localparam logic [7:0] CDFO_MASK_RESET = 8'h00;
    localparam logic [1:0] CDFO_DIV1 = 2'h0;
    localparam logic [1:0] CDFO_DIV2 = 2'h1;
    localparam logic [1:0] CDFO_DIV4 = 2'h2;
    localparam logic [1:0] CDFO_DIV8 = 2'h3;
    localparam logic [3:0] CDFO_BIT_LAST = 4'h8;
    localparam logic [3:0] CDFO_BIT_ACK = 4'h9;
    localparam int CDFO_SYNC_STAGES = 3;
    typedef enum logic [2:0] {CDFO_IDLE, CDFO_ADDR, CDFO_ADDR_ACK, CDFO_RIDX, CDFO_RIDX_ACK,
        CDFO_WDATA, CDFO_WDATA_ACK, CDFO_RDATA} cdfo_state_t;
endpackage

// >>> hdl/cdfo_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Three-stage input synchroniser
// ****************************************
module cdfo_sync
    import cdfo_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
)
(
    input wire logic clk, // Clock
    input wire logic reset, // Async reset
    input wire logic ce, // Clock enable
    input wire logic [WIDTH-1:0] d, // Async input
    output logic [WIDTH-1:0] q // Filtered level
);
    typedef struct packed
    {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } cdfo_sync_t;
    cdfo_sync_t st_r;
    cdfo_sync_t st_nxt;
    always_comb
    begin
        st_nxt = st_r;
        if (ce)
        begin
            st_nxt.s1 = d;
            st_nxt.s2 = st_r.s1;
            st_nxt.s3 = st_r.s2;
            // Change counts only when stages two and three agree
            for (int i = 0; i < WIDTH; i++)
            begin
                if (st_r.s2[i] == st_r.s3[i])
                begin
                    st_nxt.q[i] = st_r.s3[i];
                end
            end
        end
    end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= {INIT, INIT, INIT, INIT};
        end
        else
        begin
            st_r <= st_nxt;
        end
    end
    assign q = st_r.q;
endmodule
`default_nettype wire

// >>> hdl/cdfo_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module cdfo_ctrl
    import cdfo_pkg::*;
(
    input wire logic clk, // System and reference clock
    input wire logic reset, // Async reset, power-up
    input wire logic ce, // Clock enable
    input wire logic divider_select_hi, // Divider select high bit
    input wire logic divider_select_lo, // Divider select low bit
    input wire logic slave_addr_pin_hi, // Address pin high
    input wire logic slave_addr_pin_lo, // Address pin low
    input wire logic scl, // I2C clock
    input wire logic sda_in, // I2C data in
    output logic sda_out, // I2C data out, always low
    output logic sda_oe, // I2C data pull-low enable
    output logic [7:0] clock_out_pos, // Divided clock, true
    output logic [7:0] clock_out_neg, // Divided clock, complement
    output logic [7:0] clock_out_oe, // Output pair drive enable
    output logic [7:0] output_disable_mask // Register contents
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    // Reset levels match an idle bus and strapped-low pins
    logic [5:0] sync_q;
    cdfo_sync #(.WIDTH(6), .INIT(6'h03)) u_sync
    (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .d({divider_select_hi, divider_select_lo, slave_addr_pin_hi, slave_addr_pin_lo, scl, sda_in}),
        .q(sync_q)
    );
    logic [1:0] div_sel;
    logic [1:0] addr_pins;
    logic scl_s;
    logic sda_s;
    assign div_sel = sync_q[5:4];
    assign addr_pins = sync_q[3:2];
    assign scl_s = sync_q[1];
    assign sda_s = sync_q[0];

    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        logic [2:0] div_cnt;
        logic clk_q;
        logic scl_d;
        logic sda_d;
        cdfo_state_t state;
        logic [7:0] shift;
        // Rises in the byte frame: 1 to 8 data, 9 the acknowledge
        logic [3:0] bit_cnt;
        logic rd;
        logic sda_low;
        logic [7:0] mask;
    } cdfo_ctrl_t;
    cdfo_ctrl_t st_r;
    cdfo_ctrl_t st_nxt;

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] rx_byte;
    assign scl_rise = scl_s && !st_r.scl_d;
    assign scl_fall = !scl_s && st_r.scl_d;
    assign start_cond = scl_s && st_r.scl_d && st_r.sda_d && !sda_s;
    assign stop_cond = scl_s && st_r.scl_d && !st_r.sda_d && sda_s;
    assign rx_byte = {st_r.shift[6:0], sda_s};

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        st_nxt = st_r;
        if (ce)
        begin
            st_nxt.scl_d = scl_s;
            st_nxt.sda_d = sda_s;
            // Divider: a toggle per terminal count, so /1 means the raw clock
            case (div_sel)
                CDFO_DIV2:
                begin
                    st_nxt.clk_q = !st_r.clk_q;
                    st_nxt.div_cnt = 3'h0;
                end
                CDFO_DIV4:
                begin
                    st_nxt.div_cnt = st_r.div_cnt + 3'h1;
                    if (st_r.div_cnt[0])
                    begin
                        st_nxt.clk_q = !st_r.clk_q;
                        st_nxt.div_cnt = 3'h0;
                    end
                end
                CDFO_DIV8:
                begin
                    st_nxt.div_cnt = st_r.div_cnt + 3'h1;
                    if (st_r.div_cnt[1:0] == 2'h3)
                    begin
                        st_nxt.clk_q = !st_r.clk_q;
                        st_nxt.div_cnt = 3'h0;
                    end
                end
                default:
                begin
                    st_nxt.div_cnt = 3'h0;
                    st_nxt.clk_q = 1'b0;
                end
            endcase
            if (start_cond)
            begin
                // Repeated start handled the same as a start
                st_nxt.state = CDFO_ADDR;
                st_nxt.bit_cnt = 4'h0;
                st_nxt.sda_low = 1'b0;
            end
            else if (stop_cond)
            begin
                st_nxt.state = CDFO_IDLE;
                st_nxt.sda_low = 1'b0;
            end
            else if (scl_rise)
            begin
                // Sample only on rising edge: data stable while SCL high
                st_nxt.shift = rx_byte;
                if (st_r.state != CDFO_IDLE)
                begin
                    st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
                end
                if (st_r.state == CDFO_RDATA && st_r.bit_cnt == CDFO_BIT_LAST)
                begin
                    // Ack bit of read: sda high here means nack
                    st_nxt.rd = !sda_s;
                end
            end
            else if (scl_fall)
            begin
                st_nxt.sda_low = 1'b0;
                case (st_r.state)
                    CDFO_ADDR:
                    begin
                        // The fall right after a start sees a count of zero and is skipped
                        if (st_r.bit_cnt == CDFO_BIT_LAST)
                        begin
                            if (st_r.shift[7:1] == {CDFO_ADDR_FIXED, addr_pins})
                            begin
                                st_nxt.state = CDFO_ADDR_ACK;
                                st_nxt.rd = st_r.shift[0];
                                st_nxt.sda_low = 1'b1;
                            end
                            else
                            begin
                                st_nxt.state = CDFO_IDLE;
                            end
                        end
                    end
                    CDFO_ADDR_ACK:
                    begin
                        // Acknowledge clock over: a new byte frame starts
                        st_nxt.bit_cnt = 4'h0;
                        if (st_r.rd)
                        begin
                            st_nxt.state = CDFO_RDATA;
                            st_nxt.shift = st_r.mask;
                            st_nxt.sda_low = !st_r.mask[7];
                        end
                        else
                        begin
                            st_nxt.state = CDFO_RIDX;
                        end
                    end
                    CDFO_RIDX:
                    begin
                        // Index value ignored: there is one register
                        if (st_r.bit_cnt == CDFO_BIT_LAST)
                        begin
                            st_nxt.state = CDFO_RIDX_ACK;
                            st_nxt.sda_low = 1'b1;
                        end
                    end
                    CDFO_RIDX_ACK:
                    begin
                        st_nxt.state = CDFO_WDATA;
                        st_nxt.bit_cnt = 4'h0;
                    end
                    CDFO_WDATA:
                    begin
                        // Mask lands as the eighth data clock ends
                        if (st_r.bit_cnt == CDFO_BIT_LAST)
                        begin
                            st_nxt.state = CDFO_WDATA_ACK;
                            st_nxt.mask = st_r.shift;
                            st_nxt.sda_low = 1'b1;
                        end
                    end
                    CDFO_WDATA_ACK:
                    begin
                        // Extra bytes are acknowledged and overwrite the mask
                        st_nxt.state = CDFO_WDATA;
                        st_nxt.bit_cnt = 4'h0;
                    end
                    CDFO_RDATA:
                    begin
                        if (st_r.bit_cnt == CDFO_BIT_LAST)
                        begin
                            // Release for the controller's acknowledge
                            st_nxt.sda_low = 1'b0;
                        end
                        else if (st_r.bit_cnt == CDFO_BIT_ACK && st_r.rd)
                        begin
                            // Controller acked: send mask again
                            st_nxt.bit_cnt = 4'h0;
                            st_nxt.shift = st_r.mask;
                            st_nxt.sda_low = !st_r.mask[7];
                        end
                        else if (st_r.bit_cnt == CDFO_BIT_ACK)
                        begin
                            st_nxt.state = CDFO_IDLE;
                        end
                        else
                        begin
                            st_nxt.sda_low = !st_r.shift[7];
                        end
                    end
                    default:
                    begin
                        st_nxt.state = CDFO_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            st_r <= '{
                div_cnt: 3'h0,
                clk_q: 1'b0,
                scl_d: 1'b1,
                sda_d: 1'b1,
                state: CDFO_IDLE,
                shift: 8'h00,
                bit_cnt: 4'h0,
                rd: 1'b0,
                sda_low: 1'b0,
                mask: CDFO_MASK_RESET
            };
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic div_clk;
    // Divide-by-one passes the reference straight through
    assign div_clk = (div_sel == CDFO_DIV1) ? clk : st_r.clk_q;
    // Mask applied directly, no retiming to the divided clock
    for (genvar n = 0; n < 8; n++)
    begin : g_pair
        assign clock_out_pos[n] = div_clk;
        assign clock_out_neg[n] = !div_clk;
        assign clock_out_oe[n] = !st_r.mask[n];
    end
    assign output_disable_mask = st_r.mask;
    // Only ever pulls low; the bus pull-up supplies the high level
    assign sda_out = 1'b0;
    assign sda_oe = st_r.sda_low;
endmodule
`default_nettype wire

// >>> testbench/cdfo_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Port checks
// ****
module cdfo_ctrl_sva
(
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic ce, // Clock enable
    input wire logic scl, // Bus clock
    input wire logic divider_select_hi, // Select high
    input wire logic divider_select_lo, // Select low
    input wire logic sda_out, // Data level
    input wire logic sda_oe, // Data pull
    input wire logic [7:0] clock_out_pos, // True clock
    input wire logic [7:0] clock_out_neg, // Complement
    input wire logic [7:0] clock_out_oe, // Pair enable
    input wire logic [7:0] output_disable_mask // Register
);
    default clocking @(posedge clk); endclocking
    // A frozen block proves nothing, so checks pause with the enable
    default disable iff (reset || !ce);
    property p_oe; 1'b1 |-> ##[0:1] (clock_out_oe == ~output_disable_mask); endproperty
    a_oe: assert property (p_oe) else $error("pair enable differs from mask");
    property p_neg; clock_out_neg == ~clock_out_pos; endproperty
    a_neg: assert property (p_neg) else $error("pair not complementary");
    property p_fan; clock_out_pos == {8{clock_out_pos[0]}}; endproperty
    a_fan: assert property (p_fan) else $error("outputs differ");
    property p_drain; sda_out == 1'b0; endproperty
    a_drain: assert property (p_drain) else $error("data driven high");
    property p_pwr; $fell(reset) |-> output_disable_mask == 8'h00 && clock_out_oe == 8'hff; endproperty
    a_pwr: assert property (p_pwr) else $error("mask not clear after reset");
    // Sync lag keeps the answer inside the low phase
    property p_hold; scl [*6] |-> $stable(sda_oe); endproperty
    a_hold: assert property (p_hold) else $error("data moved with clock high");
    property p_upd; $changed(output_disable_mask) |-> !scl; endproperty
    a_upd: assert property (p_upd) else $error("mask changed with clock high");
    // Cycles both selects have stood high, saturating
    logic [3:0] div8_cycles;
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            div8_cycles <= 4'h0;
        end
        else if (!(divider_select_hi && divider_select_lo))
        begin
            div8_cycles <= 4'h0;
        end
        else if (div8_cycles != 4'hf)
        begin
            div8_cycles <= div8_cycles + 4'h1;
        end
    end
    property p_div8;
        (div8_cycles >= 4'hc) && $rose(clock_out_pos[0])
            |-> clock_out_pos[0] [*4] ##1 !clock_out_pos[0];
    endproperty
    a_div8: assert property (p_div8) else $error("divide by eight wrong");
    cover property ($changed(output_disable_mask));
    cover property (sda_oe [*8]);
    cover property (divider_select_hi && divider_select_lo);
endmodule
bind cdfo_ctrl cdfo_ctrl_sva u_sva (.clk(clk), .reset(reset), .ce(ce), .scl(scl),
    .divider_select_hi(divider_select_hi), .divider_select_lo(divider_select_lo), .sda_out(sda_out),
    .sda_oe(sda_oe), .clock_out_pos(clock_out_pos),
    .clock_out_neg(clock_out_neg), .clock_out_oe(clock_out_oe), .output_disable_mask(output_disable_mask));
`default_nettype wire

// >>> testbench/cdfo_i2c_host.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bus controller model
// ****
module cdfo_i2c_host
(
    input wire logic clk, // Bench clock
    input wire logic sda_wire, // Resolved data line
    output var logic scl, // Bus clock
    output var logic sda_oe // Pull data low
);
    localparam int HALF = 10;
    initial
    begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end
    task automatic step(input logic c, input logic pull);
        scl <= c;
        sda_oe <= pull;
        repeat (HALF) @(posedge clk);
    endtask
    // Clock drops first, so this also serves as a repeated start
    task automatic start();
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask
    task automatic stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
    endtask
    task automatic bitx(input logic b, output logic r);
        step(1'b0, sda_oe);
        step(1'b0, ~b);
        step(1'b1, ~b);
        r = sda_wire;
    endtask
    // Ninth bit released: low means acknowledge, read data ends in a nack
    task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic nack);
        for (int i = 7; i >= 0; i--)
        begin
            bitx(d[i], r[i]);
        end
        bitx(1'b1, nack);
    endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// Bench
// ****
module testbench
    import cdfo_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic ce = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [1:0] pins = 2'h0;
    logic sda_wire;
    logic host_scl;
    logic host_oe;
    logic sda_out;
    logic sda_oe;
    logic [7:0] pos;
    logic [7:0] neg;
    logic [7:0] oe;
    logic [7:0] mask;
    logic [7:0] rd_data;
    logic [2:0] acks;
    logic k;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int edges = 0;
    // Select, address pins, data
    logic [11:0] rows [4] = '{12'h0a5, 12'h55a, 12'ha80, 12'hf01};
    cdfo_ctrl dut (.clk(clk), .reset(reset), .ce(ce), .divider_select_hi(sel[1]), .divider_select_lo(sel[0]),
        .slave_addr_pin_hi(pins[1]), .slave_addr_pin_lo(pins[0]), .scl(host_scl), .sda_in(sda_wire),
        .sda_out(sda_out), .sda_oe(sda_oe), .clock_out_pos(pos), .clock_out_neg(neg), .clock_out_oe(oe),
        .output_disable_mask(mask));
    cdfo_i2c_host host (.clk(clk), .sda_wire(sda_wire), .scl(host_scl), .sda_oe(host_oe));
    assign sda_wire = ~(host_oe | (sda_oe & ~sda_out));
    always #2.5 clk = ~clk;
    always @(posedge pos[0]) edges++;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            n_errors++;
            results();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        if (got !== exp)
            n_errors++;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d, output logic [2:0] n);
        host.start();
        host.xfer({a, 1'b0}, rd_data, n[2]);
        host.xfer(CDFO_REG_MASK_OFS, rd_data, n[1]);
        host.xfer(d, rd_data, n[0]);
        host.stop();
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        host.start();
        host.xfer({a, 1'b1}, d, k);
        host.xfer(8'hff, d, k);
        host.stop();
    endtask
    // Counted between falling edges so no edge shares a step with the reset of the count
    task automatic measure(input logic [1:0] code);
        @(negedge clk);
        edges = 0;
        repeat (64) @(negedge clk);
        check(8'(edges), 8'(64 >> code));
    endtask
    task automatic results();
        $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        check(mask, CDFO_MASK_RESET);
        check(oe, 8'hff);
        foreach (rows[i])
        begin
            {sel, pins} <= rows[i][11:8];
            repeat (8) @(posedge clk);
            wr({CDFO_ADDR_FIXED, rows[i][9:8]}, rows[i][7:0], acks);
            check({5'h00, acks}, 8'h00);
            check(mask, rows[i][7:0]);
            check(oe, ~rows[i][7:0]);
            rd({CDFO_ADDR_FIXED, rows[i][9:8]}, rd_data);
            check(rd_data, rows[i][7:0]);
            measure(rows[i][11:10]);
        end
        // Foreign pin code, then foreign fixed bits
        wr({CDFO_ADDR_FIXED, 2'h2}, 8'hff, acks);
        check({5'h00, acks}, 8'h07);
        wr({5'h0a, 2'h3}, 8'hff, acks);
        check({5'h00, acks}, 8'h07);
        check(mask, 8'h01);
        host.start();
        host.xfer({CDFO_ADDR_FIXED, 2'h3, 1'b0}, rd_data, k);
        host.xfer(CDFO_REG_MASK_OFS, rd_data, k);
        wr({CDFO_ADDR_FIXED, 2'h3}, 8'h3c, acks);
        check(mask, 8'h3c);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        check(mask, CDFO_MASK_RESET);
        check(oe, 8'hff);
        // Enable low must hold the divider still
        ce <= 1'b0;
        @(negedge clk);
        edges = 0;
        repeat (64) @(negedge clk);
        check(8'(edges), 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        results();
    end
endmodule
`default_nettype wire
